// ===== rtl/acfs_map.svh
// Offsets, field positions, reset values and timing figures of the clock and filter control.
// Assumes a 200 MHz system clock that also serves as the internal start-up oscillator.
//
// Contract
// - Start on internal oscillator, then use main clock
// - Accept main clock only at minimum frequency
// - Failed check: no handover, flag clock error
// - Fault state outputs no data until reset
// - Clock select pin sampled once at reset
// - Select low: single-ended clock, other input grounded
// - Select high: crystal or differential across both
// - Differential option needs register mode, enable bit
// - Pin mode: reference buffers off by default
// - Per-channel positive and negative reference buffers
// - Filter per channel in register mode only
// - Two filter types, six decimation rates each
// - Low-latency filter corner at 0.204 ODR
// - Wideband flat to 0.4, stop at 0.499
// - Wideband group delay about 34 ODR periods
// - Sync rising edge restarts all filters
// - First and settled results at fixed delays
// - Two groups: common first data ready delay
// - Two groups: each group settles at own delay
`ifndef ACFS_MAP_SVH
`define ACFS_MAP_SVH

`define ACFS_ADDR_DIVDEC   8'h00
`define ACFS_ADDR_IFCFG    8'h04
`define ACFS_ADDR_FILT     8'h08
`define ACFS_ADDR_REFBUF   8'h0c
`define ACFS_ADDR_STATUS   8'h10

`define ACFS_DIV_LSB       0
`define ACFS_DECA_LSB      4
`define ACFS_DECB_LSB      8
`define ACFS_LVDS_BIT      3
`define ACFS_GRP_LSB       8
`define ACFS_NEG_LSB       8

`define ACFS_ST_CLKERR     0
`define ACFS_ST_RUN        1
`define ACFS_ST_CLKSEL     2
`define ACFS_ST_SETA       3
`define ACFS_ST_SETB       4

`define ACFS_RST_DIVDEC    11'h000
`define ACFS_RST_IFCFG     8'h00
`define ACFS_RST_FILT      16'h0000
`define ACFS_RST_REFBUF    16'h0000

`define ACFS_CLK_MHZ       200
`define ACFS_STARTUP_NS    2000
`define ACFS_CHECK_NS      5120
`define ACFS_MCLK_MIN_KHZ  1150

`endif

// ===== rtl/acfs_pkg.sv
// Types shared by the clock and filter control.
// Assumes acfs_map.svh carries the register offsets, field positions and clock timing constants.
package acfs_pkg;

  typedef enum logic [1:0] {CS_STARTUP, CS_CHECK, CS_RUN, CS_FAULT} acfs_clk_st_e;

  typedef enum logic [1:0] {DIV_4, DIV_8, DIV_32} acfs_div_e;

  typedef logic [2:0] acfs_dec_t;

  typedef struct packed {
    logic      filt_wideband;
    acfs_dec_t dec;
    logic      grp_b;
    logic      refbuf_pos;
    logic      refbuf_neg;
  } acfs_chan_cfg_s;

  typedef struct packed {
    logic ext_clk_active;
    logic opt_both_inputs;
    logic input_b_grounded;
    logic lvds_enable;
  } acfs_clk_route_s;

endpackage : acfs_pkg

// ===== rtl/acfs_top.sv
// Clock source handover, filter configuration and sync-to-data-ready timing.
// Assumes all inputs, the sampled main clock included, are synchronous to clk.
//
// The implementer's own choices: strobed register access and the register offsets.
`include "acfs_map.svh"

module acfs_top #(
  parameter int NCH = 8
) (
  input  wire logic                               clk,
  input  wire logic                               srst,
  input  wire logic                               clk_sel,
  input  wire logic                               pin_ctrl_mode,
  input  wire logic                               pin_filt_wideband,
  input  wire logic [2:0]                         pin_dec,
  input  wire logic                               mclk_in,
  input  wire logic                               sync_in,
  input  wire logic [7:0]                         reg_addr,
  input  wire logic [31:0]                        reg_wdata,
  input  wire logic                               reg_wr,
  input  wire logic                               reg_rd,
  output logic [31:0]                             reg_rdata,
  output acfs_pkg::acfs_clk_route_s               clk_route,
  output acfs_pkg::acfs_chan_cfg_s [NCH-1:0]      chan_cfg,
  output logic                                    filter_restart,
  output logic                                    data_ready_output,
  output logic                                    settled_a,
  output logic                                    settled_b,
  output logic                                    header_clk_err
);

  localparam int STARTUP_CYC = (`ACFS_STARTUP_NS * `ACFS_CLK_MHZ + 999) / 1000;
  localparam int CHECK_CYC   = (`ACFS_CHECK_NS * `ACFS_CLK_MHZ) / 1000;
  // Falling edges a clock at the minimum rate makes inside the window, rounded up
  localparam int MIN_FALLS   = (`ACFS_CHECK_NS * `ACFS_MCLK_MIN_KHZ + 999999) / 1000000;
  localparam int TW          = 22;

  acfs_pkg::acfs_clk_st_e clk_st_r;
  logic [12:0]            tmr_r;
  logic [12:0]            falls_r;
  logic                   clk_sel_r;
  logic                   sel_taken_r;
  logic                   clk_err_r;
  logic                   mclk_q_r;
  logic                   sync_q_r;
  logic                   mclk_rise;
  logic                   mclk_fall;
  logic                   sync_rise;
  logic                   running;

  logic [10:0]            divdec_r;
  logic [7:0]             ifcfg_r;
  logic [15:0]            filt_r;
  logic [15:0]            refbuf_r;

  acfs_pkg::acfs_div_e    div;
  acfs_pkg::acfs_dec_t    dec_a;
  acfs_pkg::acfs_dec_t    dec_b;
  acfs_pkg::acfs_dec_t    dec_min;
  logic                   spi_mode;
  logic                   two_grp;
  logic [1:0]             div_sh;
  logic [TW-1:0]          first_cyc;
  logic [TW-1:0]          settle_a_cyc;
  logic [TW-1:0]          settle_b_cyc;
  logic [15:0]            odr_cyc;

  logic                   armed_r;
  logic                   first_seen_r;
  logic [TW-1:0]          sync_cnt_r;
  logic [TW-1:0]          sync_cnt_nxt;
  logic [15:0]            odr_cnt_r;

  assign mclk_rise = mclk_in & ~mclk_q_r;
  assign mclk_fall = ~mclk_in & mclk_q_r;
  assign sync_rise = sync_in & ~sync_q_r;
  assign running   = (clk_st_r == acfs_pkg::CS_RUN);
  assign spi_mode  = ~pin_ctrl_mode;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mclk_q_r <= 1'b0;
      sync_q_r <= 1'b0;
    end
    else
    begin
      mclk_q_r <= mclk_in;
      sync_q_r <= sync_in;
    end
  end

  // Strap caught in the first cycle after reset release, then frozen
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      clk_sel_r   <= 1'b0;
      sel_taken_r <= 1'b0;
    end
    else if (!sel_taken_r)
    begin
      clk_sel_r   <= clk_sel;
      sel_taken_r <= 1'b1;
    end
  end

  // Clock handover: start-up on the internal clock, then measure the main clock
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      clk_st_r <= acfs_pkg::CS_STARTUP;
      tmr_r    <= 13'h0000;
      falls_r  <= 13'h0000;
    end
    else
    begin
      unique case (clk_st_r)
        acfs_pkg::CS_STARTUP:
        begin
          tmr_r   <= tmr_r + 13'h0001;
          falls_r <= 13'h0000;
          if (tmr_r == 13'(STARTUP_CYC - 1))
          begin
            clk_st_r <= acfs_pkg::CS_CHECK;
            tmr_r    <= 13'h0000;
          end
        end
        acfs_pkg::CS_CHECK:
        begin
          tmr_r <= tmr_r + 13'h0001;
          if (mclk_fall)
            falls_r <= falls_r + 13'h0001;
          // A fall in the window's last cycle still counts
          if (tmr_r == 13'(CHECK_CYC - 1))
          begin
            if ((falls_r + {12'h000, mclk_fall}) >= 13'(MIN_FALLS))
              clk_st_r <= acfs_pkg::CS_RUN;
            else
              clk_st_r <= acfs_pkg::CS_FAULT;
          end
        end
        acfs_pkg::CS_RUN:
          clk_st_r <= acfs_pkg::CS_RUN;
        // Only a reset leaves the fault state
        acfs_pkg::CS_FAULT:
          clk_st_r <= acfs_pkg::CS_FAULT;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      clk_err_r <= 1'b0;
    else if (clk_st_r == acfs_pkg::CS_FAULT)
      clk_err_r <= 1'b1;
  end

  // Held until srst; software has no way to clear it
  assign header_clk_err = clk_err_r;

  always_comb
  begin
    clk_route.ext_clk_active   = running;
    clk_route.opt_both_inputs  = clk_sel_r;
    clk_route.input_b_grounded = ~clk_sel_r;
    clk_route.lvds_enable      = clk_sel_r & spi_mode & ifcfg_r[`ACFS_LVDS_BIT];
  end

  // Register writes; settings still steer logic only in register mode
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      divdec_r <= `ACFS_RST_DIVDEC;
      ifcfg_r  <= `ACFS_RST_IFCFG;
      filt_r   <= `ACFS_RST_FILT;
      refbuf_r <= `ACFS_RST_REFBUF;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        `ACFS_ADDR_DIVDEC: divdec_r <= reg_wdata[10:0];
        `ACFS_ADDR_IFCFG:  ifcfg_r  <= reg_wdata[7:0];
        `ACFS_ADDR_FILT:   filt_r   <= reg_wdata[15:0];
        `ACFS_ADDR_REFBUF: refbuf_r <= reg_wdata[15:0];
        default:           ;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        `ACFS_ADDR_DIVDEC: reg_rdata <= {21'h000000, divdec_r};
        `ACFS_ADDR_IFCFG:  reg_rdata <= {24'h000000, ifcfg_r};
        `ACFS_ADDR_FILT:   reg_rdata <= {16'h0000, filt_r};
        `ACFS_ADDR_REFBUF: reg_rdata <= {16'h0000, refbuf_r};
        `ACFS_ADDR_STATUS: reg_rdata <= {27'h0000000, settled_b, settled_a, clk_sel_r,
                                         running, clk_err_r};
        default:           reg_rdata <= 32'h0000_0000;
      endcase
    end
    // Data stand one cycle only, so a late sampler sees zero
    else
      reg_rdata <= 32'h0000_0000;
  end

  // Pin mode drives one filter and rate to every channel, single group
  always_comb
  begin
    if (spi_mode)
    begin
      div   = acfs_pkg::acfs_div_e'(divdec_r[`ACFS_DIV_LSB +: 2]);
      dec_a = divdec_r[`ACFS_DECA_LSB +: 3];
      dec_b = divdec_r[`ACFS_DECB_LSB +: 3];
    end
    else
    begin
      div   = acfs_pkg::DIV_4;
      dec_a = pin_dec;
      dec_b = pin_dec;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++)
    begin : g_chan
      logic grp_b;
      assign grp_b = spi_mode & filt_r[`ACFS_GRP_LSB + ch];
      always_comb
      begin
        // Type bit selects the filter response only; the delay tables depend on the rate alone
        chan_cfg[ch].filt_wideband = spi_mode ? filt_r[ch]
                                              : pin_filt_wideband;
        chan_cfg[ch].dec           = grp_b ? dec_b : dec_a;
        chan_cfg[ch].grp_b         = grp_b;
        chan_cfg[ch].refbuf_pos    = spi_mode & refbuf_r[ch];
        chan_cfg[ch].refbuf_neg    = spi_mode & refbuf_r[`ACFS_NEG_LSB + ch];
      end
    end
  endgenerate

  assign two_grp = spi_mode & (|filt_r[`ACFS_GRP_LSB +: NCH]);

  // First data ready, one group, divide-by-four
  function automatic logic [TW-1:0] first_one(input acfs_pkg::acfs_dec_t d);
    unique case (d)
      3'h0:    first_one = 22'd336;
      3'h1:    first_one = 22'd620;
      3'h2:    first_one = 22'd1187;
      3'h3:    first_one = 22'd2325;
      3'h4:    first_one = 22'd4601;
      default: first_one = 22'd9153;
    endcase
  endfunction : first_one

  // Settled data, one group, divide-by-four
  function automatic logic [TW-1:0] settle_one(input acfs_pkg::acfs_dec_t d);
    unique case (d)
      3'h0:    settle_one = 22'd8400;
      3'h1:    settle_one = 22'd16748;
      3'h2:    settle_one = 22'd33443;
      3'h3:    settle_one = 22'd66837;
      3'h4:    settle_one = 22'd133625;
      default: settle_one = 22'd267201;
    endcase
  endfunction : settle_one

  // Settled data per group when two groups are in use, divide-by-four
  function automatic logic [TW-1:0] settle_two(input acfs_pkg::acfs_dec_t d);
    unique case (d)
      3'h0:    settle_two = 22'd8822;
      3'h1:    settle_two = 22'd17014;
      3'h2:    settle_two = 22'd33526;
      3'h3:    settle_two = 22'd66934;
      3'h4:    settle_two = 22'd133622;
      default: settle_two = 22'd267253;
    endcase
  endfunction : settle_two

  // Slower dividers scale the divide-by-four figures; exact only at divide-by-four
  always_comb
  begin
    unique case (div)
      acfs_pkg::DIV_8:  div_sh = 2'h1;
      acfs_pkg::DIV_32: div_sh = 2'h3;
      default:          div_sh = 2'h0;
    endcase
    dec_min = (two_grp && (dec_b < dec_a)) ? dec_b : dec_a;
    if (two_grp)
    begin
      first_cyc    = 22'd758 << div_sh;
      settle_a_cyc = settle_two(dec_a) << div_sh;
      settle_b_cyc = settle_two(dec_b) << div_sh;
    end
    else
    begin
      first_cyc    = first_one(dec_a) << div_sh;
      settle_a_cyc = settle_one(dec_a) << div_sh;
      // One group: the group B flag tracks group A
      settle_b_cyc = settle_one(dec_a) << div_sh;
    end
    // Output period in main-clock cycles: divider times decimation
    // Shift needs four bits: divider and rate steps together reach eight
    odr_cyc = 16'(16'h0080 << (4'(div_sh) + 4'(dec_min)));
  end

  assign sync_cnt_nxt = sync_cnt_r + 22'h000001;

  // Sync restarts every filter; delays count main-clock rises after the edge
  // A new sync outranks a settle reached in the same cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      armed_r      <= 1'b0;
      first_seen_r <= 1'b0;
      sync_cnt_r   <= 22'h000000;
      odr_cnt_r    <= 16'h0000;
      settled_a    <= 1'b0;
      settled_b    <= 1'b0;
    end
    else if (sync_rise && running)
    begin
      armed_r      <= 1'b1;
      first_seen_r <= 1'b0;
      sync_cnt_r   <= 22'h000000;
      odr_cnt_r    <= 16'h0000;
      settled_a    <= 1'b0;
      settled_b    <= 1'b0;
    end
    else if (armed_r && mclk_rise)
    begin
      if (!(settled_a && settled_b))
        sync_cnt_r <= sync_cnt_nxt;
      if (sync_cnt_nxt == first_cyc)
        first_seen_r <= 1'b1;
      if (sync_cnt_nxt == settle_a_cyc)
        settled_a <= 1'b1;
      if (sync_cnt_nxt == (two_grp ? settle_b_cyc : settle_a_cyc))
        settled_b <= 1'b1;
      if (first_seen_r)
        odr_cnt_r <= (odr_cnt_r == odr_cyc - 16'h0001) ? 16'h0000 : odr_cnt_r + 16'h0001;
    end
  end

  // Restart pulse and data ready only once the main clock owns timing
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      filter_restart    <= 1'b0;
      data_ready_output <= 1'b0;
    end
    else
    begin
      filter_restart    <= sync_rise & running;
      // No pulse in the restart cycle: it would belong to the old run
      data_ready_output <= running & armed_r & mclk_rise & ~sync_rise &
                           ((!first_seen_r && sync_cnt_nxt == first_cyc) ||
                            (first_seen_r && odr_cnt_r == odr_cyc - 16'h0001));
    end
  end

endmodule : acfs_top

// ===== verif/acfs_host.sv
// Host model: main clock source and sync driver.
// Assumes the same clk as the device; main clock made as sampled data.
module acfs_host (
  input wire logic clk,
  input wire logic mclk_on,
  input wire logic slow,
  input wire logic sync_req,
  output logic     mclk_in,
  output logic     sync_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_r;
  logic [2:0] hold_r;
  initial
  begin
    mclk_in = 1'b0;
    sync_in = 1'b0;
    div_r = 2'h0;
    hold_r = 3'h0;
  end
  // A stopped source stands low, never at its last level
  always @(posedge clk)
  begin
    div_r <= div_r + 2'h1;
    if (!mclk_on)
      mclk_in <= 1'b0;
    else if (!slow || div_r == 2'h3)
      mclk_in <= !mclk_in;
  end
  // Sync held a few cycles, then low until the next request
  always @(posedge clk)
  begin
    if (sync_req)
    begin
      hold_r <= 3'h4;
      sync_in <= 1'b1;
    end
    else if (hold_r != 3'h0)
      hold_r <= hold_r - 3'h1;
    else
      sync_in <= 1'b0;
  end
endmodule : acfs_host

// ===== verif/acfs_top_checker.sv
// Assertions on clock handover, config and sync outputs of acfs_top.
// Assumes it is bound to acfs_top and sees only its ports.
module acfs_top_checker #(
  parameter int NCH = 8
) (
  input wire logic                          clk,
  input wire logic                          srst,
  input wire logic                          clk_sel,
  input wire logic                          pin_ctrl_mode,
  input wire logic                          sync_in,
  input wire acfs_pkg::acfs_clk_route_s     clk_route,
  input wire acfs_pkg::acfs_chan_cfg_s [NCH-1:0] chan_cfg,
  input wire logic                          filter_restart,
  input wire logic                          data_ready_output,
  input wire logic                          settled_a,
  input wire logic                          settled_b,
  input wire logic                          header_clk_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_on;
  always_comb
  begin
    ref_on = 1'b0;
    for (int i = 0; i < NCH; i++)
      ref_on = ref_on | chan_cfg[i].refbuf_pos | chan_cfg[i].refbuf_neg;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence sync_edge_s;
    !sync_in ##1 sync_in;
  endsequence
  sequence running_s;
    clk_route.ext_clk_active;
  endsequence
  restart_on_sync_a: assert property (sync_edge_s ##0 running_s |=> filter_restart)
    else $error("no restart after sync edge");
  restart_pulse_a: assert property (filter_restart |=> !filter_restart)
    else $error("restart longer than one cycle");
  ready_pulse_a: assert property (data_ready_output |=> !data_ready_output)
    else $error("data ready longer than one cycle");
  quiet_fault_a: assert property (!clk_route.ext_clk_active
    |=> !filter_restart && !data_ready_output)
    else $error("output while not running");
  err_sticky_a: assert property (header_clk_err |=> header_clk_err)
    else $error("clock error dropped");
  err_blocks_a: assert property (header_clk_err |-> !clk_route.ext_clk_active)
    else $error("handover despite clock error");
  startup_first_a: assert property ($fell(srst) |-> !clk_route.ext_clk_active [*8])
    else $error("main clock used during start-up");
  route_sel_a: assert property (running_s
    |-> clk_route.input_b_grounded != clk_route.opt_both_inputs)
    else $error("clock input routing inconsistent");
  sel_latch_a: assert property ($fell(srst)
    |=> clk_route.opt_both_inputs == $past(clk_sel))
    else $error("clock option not taken from strap");
  lvds_mode_a: assert property (clk_route.lvds_enable
    |-> clk_route.opt_both_inputs && !pin_ctrl_mode)
    else $error("differential option in wrong mode");
  pin_ref_off_a: assert property (pin_ctrl_mode |-> !ref_on)
    else $error("reference buffer on in pin mode");
  settle_clear_a: assert property (filter_restart |-> ##1 (!settled_a && !settled_b))
    else $error("settled flag kept after sync");
endmodule : acfs_top_checker

bind acfs_top acfs_top_checker #(.NCH(NCH)) u_chk (.clk(clk), .srst(srst), .clk_sel(clk_sel),
  .pin_ctrl_mode(pin_ctrl_mode), .sync_in(sync_in), .clk_route(clk_route),
  .chan_cfg(chan_cfg), .filter_restart(filter_restart), .data_ready_output(data_ready_output),
  .settled_a(settled_a), .settled_b(settled_b), .header_clk_err(header_clk_err));

// ===== verif/adc_clock_and_filter_sync_tb.sv
// Self-checking bench for acfs_top with the host model.
// Assumes the 200 MHz clock also acts as the start-up oscillator.
module adc_clock_and_filter_sync_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NCH = 8;
  logic clk, srst, clk_sel, pin_ctrl_mode, pin_filt_wideband, reg_wr, reg_rd;
  logic mclk_in, sync_in, mclk_on, slow, sync_req, sync_q, mclk_q;
  logic filter_restart, data_ready_output, settled_a, settled_b, header_clk_err;
  logic [2:0] pin_dec;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v, dd, fv, rv;
  acfs_pkg::acfs_clk_route_s clk_route;
  acfs_pkg::acfs_chan_cfg_s [NCH-1:0] chan_cfg;
  int errors, n_compared, rise_cnt, seed, c;

  acfs_top #(.NCH(NCH)) dut (.clk(clk), .srst(srst), .clk_sel(clk_sel),
    .pin_ctrl_mode(pin_ctrl_mode), .pin_filt_wideband(pin_filt_wideband),
    .pin_dec(pin_dec), .mclk_in(mclk_in), .sync_in(sync_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .clk_route(clk_route), .chan_cfg(chan_cfg), .filter_restart(filter_restart),
    .data_ready_output(data_ready_output), .settled_a(settled_a),
    .settled_b(settled_b), .header_clk_err(header_clk_err));
  acfs_host host (.clk(clk), .mclk_on(mclk_on), .slow(slow), .sync_req(sync_req),
    .mclk_in(mclk_in), .sync_in(sync_in));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Main clock rises counted since the last sync edge
  always @(posedge clk)
  begin
    sync_q <= sync_in;
    mclk_q <= mclk_in;
    if (sync_in && !sync_q)
      rise_cnt <= 0;
    else if (mclk_in && !mclk_q)
      rise_cnt <= rise_cnt + 1;
  end

  function automatic logic [31:0] exp_cfg(input int i);
    acfs_pkg::acfs_chan_cfg_s e;
    e.filt_wideband = fv[i];
    e.grp_b = fv[8+i];
    e.dec = fv[8+i] ? dd[10:8] : dd[6:4];
    e.refbuf_pos = rv[i];
    e.refbuf_neg = rv[8+i];
    return {25'h0, e};
  endfunction : exp_cfg

  task automatic results;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask : rd

  // Kinds: 0 data ready, 1 settled a, 2 settled b, 3 handover done
  task automatic wait_ev(input int k, output int cnt);
    bit hit;
    hit = 1'b0;
    for (int i = 0; i < 40000 && !hit; i++)
    begin
      @(posedge clk);
      hit = k == 0 ? data_ready_output === 1'b1 : k == 1 ? settled_a === 1'b1 :
            k == 2 ? settled_b === 1'b1 : clk_route.ext_clk_active === 1'b1;
    end
    cnt = rise_cnt;
    if (!hit)
    begin
      errors++;
      results();
    end
  endtask : wait_ev

  task automatic do_reset(input logic sel);
    @(posedge clk);
    srst <= 1'b1;
    clk_sel <= sel;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
  endtask : do_reset

  task automatic sync_go;
    @(posedge clk);
    sync_req <= 1'b1;
    @(posedge clk);
    sync_req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : sync_go

  initial
  begin
    {srst, clk_sel, pin_ctrl_mode, pin_filt_wideband, reg_wr, reg_rd} = 6'h20;
    {mclk_on, slow, sync_req, pin_dec, reg_addr, reg_wdata} = '0;
    {errors, n_compared, rise_cnt, seed} = {32'h0, 32'h0, 32'h0, 32'd18366};
    do_reset(1'b0);
    repeat (1500) @(posedge clk);
    chk("clk_err", header_clk_err, 32'h1);
    rd(8'h10, v);
    chk("status", v, 32'h1);
    sync_go();
    repeat (20) @(posedge clk);
    chk("clk_err", header_clk_err, 32'h1);
    mclk_on <= 1'b1;
    for (int s = 0; s < 2; s++)
    begin
      do_reset(s[0]);
      wait_ev(3, c);
      chk("both_in", clk_route.opt_both_inputs, s);
      chk("grounded", clk_route.input_b_grounded, 1 - s);
      clk_sel <= !s[0];
      rd(8'h10, v);
      chk("status", v, 32'h2 | (s << 2));
    end
    wr(8'h04, 32'h8);
    chk("lvds", clk_route.lvds_enable, 32'h1);
    pin_ctrl_mode <= 1'b1;
    @(posedge clk);
    chk("lvds", clk_route.lvds_enable, 32'h0);
    pin_ctrl_mode <= 1'b0;
    for (int r = 0; r < 4; r++)
    begin
      dd = ((($random(seed) & 32'hffff) % 6) << 8) | ((($random(seed) & 32'hffff) % 6) << 4);
      fv = $random(seed) & 32'hffff;
      rv = $random(seed) & 32'hffff;
      wr(8'h00, dd);
      wr(8'h08, fv);
      wr(8'h0c, rv);
      for (int i = 0; i < NCH; i++)
        chk("cfg", {25'h0, chan_cfg[i]}, exp_cfg(i));
      rd(8'h0c, v);
      chk("refbuf", v, rv);
    end
    for (int d = 0; d < 6; d++)
    begin
      pin_ctrl_mode <= 1'b1;
      pin_dec <= d[2:0];
      pin_filt_wideband <= 1'($random(seed));
      @(posedge clk);
      for (int i = 0; i < NCH; i++)
        chk("pin_cfg", {25'h0, chan_cfg[i]},
            {25'h0, pin_filt_wideband, pin_dec, 3'h0});
    end
    pin_ctrl_mode <= 1'b0;
    rd(8'h14, v);
    chk("unmapped", v, 32'h0);
    slow <= 1'b1;
    wr(8'h00, 32'h0);
    wr(8'h08, 32'hff);
    sync_go();
    wait_ev(0, c);
    chk("first_one", c, 32'd336);
    slow <= 1'b0;
    // Divide-by-eight, x512: one output every 8 * 512 main-clock periods
    wr(8'h00, 32'h41);
    sync_go();
    wait_ev(0, c);
    v = c;
    wait_ev(0, c);
    chk("odr", c - v, 32'd4096);
    wr(8'h00, 32'h100);
    wr(8'h08, 32'hf0ff);
    sync_go();
    wait_ev(0, c);
    chk("first_two", c, 32'd758);
    wait_ev(1, c);
    chk("settle_a", c, 32'd8822);
    wait_ev(2, c);
    chk("settle_b", c, 32'd17014);
    rd(8'h10, v);
    chk("status", v, 32'h1e);
    sync_go();
    chk("settle_clr", {settled_b, settled_a}, 32'h0);
    results();
  end
endmodule : adc_clock_and_filter_sync_tb
